// File: core/dll_mode_ctrl.sv
`timescale 1ns/1ps
`include "dll_mode_map.svh"

// Operation
// R1: chip select low, strobes high registers a no-operation; ongoing work continues
// R2: chip select high ignores command pins; ongoing work continues
// R3: mode register 1 bit 0 set disables the loop until cleared
// R4: the disable bit may change during initialization or later
// R5: loop off supports only read and write latency of six
// R6: loop off starts read strobe timing one cycle earlier
// R7: controller keeps clock under loop-off maximum and realigns read data
// R8: controller idles banks and termination before disabling the loop
// R9: controller disables loop, enters self-refresh, changes clock, restarts it
// R10: controller holds clock enable high, termination low after self-refresh exit
// R11: controller rewrites mode registers after exit delay
// R12: controller enters self-refresh to turn the loop back on
// R13: controller clears disable bit then starts loop reset via mode register 0
// R14: locked-loop commands wait the full lock time
// R15: controller keeps clock period constant in normal operation
// R16: frequency changes only in self-refresh or precharge power-down
// R17: in self-refresh the device ignores the clock after entry hold time
// R18: new frequency stays within the speed grade range
// R19: in power-down termination stays off, controller holds termination low
// R20: controller waits hold time and keeps clock enable, termination low
// R21: controller restarts clock, exits, then resets the loop
// R22: during re-lock controller holds termination low; afterwards device runs
module dll_mode_ctrl
    import dll_mode_pkg::*;
#(
    parameter int LOCK_CYCLES = `LOCK_CYCLES
)(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // memory pins from the controller
    input  wire logic        ck_in,
    input  wire logic        cke_in,
    input  wire logic        odt_in,
    input  wire logic        cs_n_in,
    input  wire logic        ras_n_in,
    input  wire logic        cas_n_in,
    input  wire logic        we_n_in,
    input  wire logic [1:0]  ba_in,
    input  wire logic [12:0] addr_in,
    // latencies from the rest of the device
    input  wire logic [3:0]  cas_latency_in,
    input  wire logic [3:0]  write_latency_in,
    input  wire logic [3:0]  additive_latency_in,
    // status
    output logic             dll_off_out,
    output logic             dll_locked_out,
    output logic             latency_ok_out,
    output logic [4:0]       read_strobe_delay_out,
    output logic             self_refresh_out,
    output logic             power_down_out,
    output logic             clock_ignored_out,
    output logic             nop_out
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    cmd_pins_s pins_meta;
    cmd_pins_s pins_sync;
    cmd_pins_s pins_prev;
    logic      ck_meta;
    logic      ck_sync;
    logic      ck_prev;
    cmd_pins_s pins_raw;

    assign pins_raw = '{cs_n: cs_n_in, ras_n: ras_n_in, cas_n: cas_n_in, we_n: we_n_in,
                        cke: cke_in, odt: odt_in, ba: ba_in, addr: addr_in};

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pins_meta <= '{cs_n: 1'h1, ras_n: 1'h1, cas_n: 1'h1, we_n: 1'h1, default: '0};
            pins_sync <= '{cs_n: 1'h1, ras_n: 1'h1, cas_n: 1'h1, we_n: 1'h1, default: '0};
            pins_prev <= '{cs_n: 1'h1, ras_n: 1'h1, cas_n: 1'h1, we_n: 1'h1, default: '0};
            ck_meta   <= 1'h0;
            ck_sync   <= 1'h0;
            ck_prev   <= 1'h0;
        end else begin
            pins_meta <= pins_raw;
            pins_sync <= pins_meta;
            ck_meta   <= ck_in;
            ck_sync   <= ck_meta;
            ck_prev   <= ck_sync;
            if (ck_sync && !ck_prev) begin
                pins_prev <= pins_sync;
            end
        end
    end

    // ****************************************
    // command decode on link clock rising edge
    // ****************************************
    logic ck_rise;
    cmd_e cmd;

    assign ck_rise = ck_sync && !ck_prev;

    cmd_decode u_decode (
        .pins_in     (pins_sync),
        .cke_prev_in (pins_prev.cke),
        .cmd_out     (cmd)
    );

    // ****************************************
    // loop mode and power state
    // ****************************************
    power_state_e state;
    power_state_e next_state;
    logic         dll_off;
    logic         next_dll_off;
    logic [15:0]  lock_cnt;
    logic [15:0]  next_lock_cnt;
    logic         locked;
    logic         next_locked;
    logic         nop;
    logic         next_nop;

    always_comb begin
        next_state    = state;
        next_dll_off  = dll_off;
        next_lock_cnt = lock_cnt;
        next_locked   = locked;
        next_nop      = 1'h0;
        if (ck_rise) begin
            case (state)
                ST_ACTIVE, ST_RELOCK: begin
                    // deselect and nop change nothing while cke stays high; a relock keeps counting
                    next_nop = (cmd == CMD_NOP);                           // [R1]
                    if (cmd == CMD_MODE_SET && pins_sync.ba == `MR_SEL_MR1) begin
                        // disable bit may be written in the active or relock state  [R4]
                        next_dll_off = pins_sync.addr[`MR1_DLL_OFF_BIT];   // [R3]
                        if (pins_sync.addr[`MR1_DLL_OFF_BIT]) begin
                            next_locked = 1'h0;
                            next_state  = ST_ACTIVE;
                        end
                    end else if (cmd == CMD_MODE_SET && pins_sync.ba == `MR_SEL_MR0
                                 && pins_sync.addr[`MR0_DLL_RESET_BIT] && !dll_off) begin
                        next_locked   = 1'h0;
                        next_lock_cnt = 16'(LOCK_CYCLES);
                        next_state    = ST_RELOCK;
                    end else if (cmd == CMD_SELF_REFRESH) begin
                        next_state = ST_SELF_REFRESH;
                    end else if (pins_prev.cke && !pins_sync.cke && cmd != CMD_OTHER) begin
                        next_state = ST_POWER_DOWN;
                    end else if (state == ST_RELOCK) begin
                        // after lock time, run at the new frequency  [R22]
                        if (lock_cnt <= 16'h0001) begin
                            next_lock_cnt = 16'h0000;
                            next_locked   = 1'h1;
                            next_state    = ST_ACTIVE;
                        end else begin
                            next_lock_cnt = lock_cnt - 16'h0001;
                        end
                    end
                end
                ST_SELF_REFRESH, ST_POWER_DOWN: begin
                    // clock content is ignored here; only cke return counts  [R17]
                    if (pins_sync.cke) begin
                        next_state = ST_ACTIVE;
                    end
                end
                default: begin
                    next_state = ST_ACTIVE;
                end
            endcase
        end
        // exit is only taken at a clock edge; a parked clock holds the state  [R17]
        if ((state == ST_SELF_REFRESH || state == ST_POWER_DOWN) && pins_sync.cke
            && !ck_rise) begin
            next_state = state;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state    <= ST_ACTIVE;
            dll_off  <= `DLL_OFF_RESET;
            lock_cnt <= 16'h0000;
            locked   <= 1'h0;
            nop      <= 1'h0;
        end else begin
            state    <= next_state;
            dll_off  <= next_dll_off;
            lock_cnt <= next_lock_cnt;
            locked   <= next_locked;
            nop      <= next_nop;
        end
    end

    // ****************************************
    // latency and strobe timing
    // ****************************************
    logic [4:0] next_strobe;
    logic       next_lat_ok;

    always_comb begin
        next_strobe = 5'(additive_latency_in) + 5'(cas_latency_in);
        if (dll_off) begin
            next_strobe = next_strobe - 5'h01;                             // [R6]
        end
        next_lat_ok = !dll_off || (cas_latency_in == `DLL_OFF_LATENCY
                                   && write_latency_in == `DLL_OFF_LATENCY); // [R5]
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            read_strobe_delay_out <= 5'h00;
            latency_ok_out        <= 1'h1;
            dll_off_out           <= 1'h0;
            dll_locked_out        <= 1'h0;
            self_refresh_out      <= 1'h0;
            power_down_out        <= 1'h0;
            clock_ignored_out     <= 1'h0;
            nop_out               <= 1'h0;
        end else begin
            read_strobe_delay_out <= next_strobe;
            latency_ok_out        <= next_lat_ok;
            dll_off_out           <= dll_off;
            dll_locked_out        <= locked && !dll_off;
            self_refresh_out      <= (state == ST_SELF_REFRESH);
            power_down_out        <= (state == ST_POWER_DOWN);
            clock_ignored_out     <= (state == ST_SELF_REFRESH);          // [R17]
            nop_out               <= nop;
        end
    end

endmodule

// File: core/dll_mode_map.svh
`ifndef DLL_MODE_MAP_SVH
`define DLL_MODE_MAP_SVH

// mode register select values on the bank address pins
`define MR_SEL_MR0          2'h0
`define MR_SEL_MR1          2'h1
// field positions within the address bus
`define MR1_DLL_OFF_BIT     0
`define MR0_DLL_RESET_BIT   8
// reset values
`define DLL_OFF_RESET       1'h0
// only latency setting supported while the loop is off
`define DLL_OFF_LATENCY     4'h6
// loop lock time in link clock cycles
`define LOCK_CYCLES         512
// clock periods of the link clock (bench value 48 ns) sampled by clk_in (4 ns)
`define LINK_PERIOD_NS      48
`define CORE_PERIOD_NS      4
`define IDLE_EDGES_CK       ((`LINK_PERIOD_NS * 4) / `CORE_PERIOD_NS)

`endif

// File: core/dll_mode_pkg.sv
package dll_mode_pkg;

    typedef enum logic [2:0] {
        CMD_DESELECT,
        CMD_NOP,
        CMD_MODE_SET,
        CMD_SELF_REFRESH,
        CMD_POWER_DOWN,
        CMD_OTHER
    } cmd_e;

    typedef struct packed {
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic        cke;
        logic        odt;
        logic [1:0]  ba;
        logic [12:0] addr;
    } cmd_pins_s;

    typedef enum {
        ST_ACTIVE,
        ST_SELF_REFRESH,
        ST_POWER_DOWN,
        ST_RELOCK
    } power_state_e;

endpackage

// File: core/cmd_decode.sv
`timescale 1ns/1ps

// combinational command decode of the sampled pins
module cmd_decode
    import dll_mode_pkg::*;
(
    // sampled pins
    input  wire cmd_pins_s pins_in,
    input  wire logic      cke_prev_in,
    // decoded command
    output cmd_e           cmd_out
);

    always_comb begin
        if (pins_in.cs_n) begin
            cmd_out = CMD_DESELECT;                                   // [R2]
        end else if (pins_in.ras_n && pins_in.cas_n && pins_in.we_n) begin
            cmd_out = CMD_NOP;                                        // [R1]
        end else if (!pins_in.ras_n && !pins_in.cas_n && !pins_in.we_n) begin
            if (cke_prev_in && !pins_in.cke) begin
                cmd_out = CMD_SELF_REFRESH;
            end else begin
                cmd_out = CMD_MODE_SET;
            end
        end else begin
            cmd_out = CMD_OTHER;
        end
    end

endmodule

// File: tb/dll_mode_ctrl_sva.sv
`timescale 1ns/1ps
`include "dll_mode_map.svh"
module dll_mode_ctrl_sva
    import dll_mode_pkg::*;
(
    // clock, reset, pins
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic       cs_n_in,
    // latencies
    input wire logic [3:0] cas_latency_in,
    input wire logic [3:0] write_latency_in,
    input wire logic [3:0] additive_latency_in,
    // status
    input wire logic       dll_off_out,
    input wire logic       dll_locked_out,
    input wire logic       latency_ok_out,
    input wire logic [4:0] read_strobe_delay_out,
    input wire logic       self_refresh_out,
    input wire logic       power_down_out,
    input wire logic       clock_ignored_out,
    input wire logic       nop_out
);
    // ****
    // checks
    // ****
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [11:0] lat;
    logic [1:0]  age;
    logic [4:0]  sum;
    assign lat = {cas_latency_in, write_latency_in, additive_latency_in};
    assign sum = 5'(cas_latency_in) + 5'(additive_latency_in);
    // outputs are registered, so skip the edges right after reset
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in) age <= 2'h0;
        else if (age != 2'h3) age <= age + 2'h1;
    sequence s_settled;
        age == 2'h3 && $stable(lat) && $stable(dll_off_out);
    endsequence
    property p_nop_pulse; nop_out |=> !nop_out; endproperty
    a_nop_pulse: assert property (p_nop_pulse) else $error("nop too long");
    property p_desel_quiet; cs_n_in [*8] |-> !nop_out; endproperty
    a_desel_quiet: assert property (p_desel_quiet) else $error("nop unselected");
    property p_desel_keep; cs_n_in [*8] |-> $stable(dll_off_out); endproperty
    a_desel_keep: assert property (p_desel_keep) else $error("mode unselected");
    property p_off_unlocked; dll_off_out && $past(dll_off_out) |-> !dll_locked_out; endproperty
    a_off_unlocked: assert property (p_off_unlocked) else $error("locked off");
    property p_lat;
        s_settled |-> latency_ok_out == !(dll_off_out && (cas_latency_in != `DLL_OFF_LATENCY
            || write_latency_in != `DLL_OFF_LATENCY));
    endproperty
    a_lat: assert property (p_lat) else $error("latency flag");
    property p_strobe_off; s_settled ##0 dll_off_out |-> read_strobe_delay_out == sum - 5'h1;
    endproperty
    a_strobe_off: assert property (p_strobe_off) else $error("strobe off");
    property p_strobe_on; s_settled ##0 !dll_off_out |-> read_strobe_delay_out == sum; endproperty
    a_strobe_on: assert property (p_strobe_on) else $error("strobe on");
    property p_ignore;
        clock_ignored_out == self_refresh_out && !(self_refresh_out && power_down_out);
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignore outside");
    property p_lock;
        $rose(dll_locked_out) |-> !self_refresh_out && !power_down_out && !dll_off_out;
    endproperty
    a_lock: assert property (p_lock) else $error("lock state");
    c_off: cover property (dll_off_out && nop_out);
    c_lock: cover property ($rose(dll_locked_out));
    c_ign: cover property (clock_ignored_out);
    c_pdown: cover property (power_down_out);
endmodule

bind dll_mode_ctrl dll_mode_ctrl_sva dll_mode_ctrl_sva_i (.clk_in, .rst_in, .cs_n_in,
    .cas_latency_in, .write_latency_in, .additive_latency_in, .dll_off_out, .dll_locked_out,
    .latency_ok_out, .read_strobe_delay_out, .self_refresh_out, .power_down_out,
    .clock_ignored_out, .nop_out);

// File: tb/ctrl_model.sv
`timescale 1ns/1ps
module ctrl_model
    import dll_mode_pkg::*;
(
    // clocks
    input  wire logic clk_in,
    input  wire logic run_in,
    // pins
    output logic      ck_out,
    output cmd_pins_s pins_out
);
    // ****
    // link side
    // ****
    logic       ck = 1'b0;
    logic [2:0] half = 3'h0;
    assign ck_out = ck;
    initial pins_out = cmd_pins_s'(21'h110000);
    // fixed period; parks low whenever run_in drops, whatever the device state
    always @(posedge clk_in) begin
        half <= (half == 3'h5) ? 3'h0 : half + 3'h1;
        if (half == 3'h5 && (run_in || ck))
            ck <= ~ck;
    end
    // odt always low; cke order set by caller
    task automatic send(input cmd_pins_s p);
        cmd_pins_s idle;
        idle = ~p;
        idle.cs_n = 1'b1;
        idle.cke = p.cke;
        idle.odt = 1'b0;
        @(posedge clk_in iff (half == 3'h5 && ck));
        pins_out <= p;
        @(posedge clk_in iff (half == 3'h5 && ck));
        // deselected: junk on the rest
        pins_out <= idle;
        repeat (4) @(posedge clk_in);
    endtask
endmodule

// File: tb/dll_mode_ctrl_test.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module dll_mode_ctrl_test;
    import dll_mode_pkg::*;
    localparam int LOCK = 8;
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       run = 1'b1;
    logic       ck;
    cmd_pins_s  pins;
    logic [3:0] cl = 4'h6;
    logic [3:0] cwl = 4'h6;
    logic [3:0] al = 4'h0;
    logic [3:0] c;
    logic [4:0] rsd;
    logic       dll_off, locked, lat_ok, sref, pdown, ck_ign, nop;
    int         n_fail = 0;
    int         comparisons = 0;
    int         cycles = 0;
    int         nops = 0;
    int         base, r;
    ctrl_model ctrl_model_i (.clk_in(clk_in), .run_in(run), .ck_out(ck), .pins_out(pins));
    dll_mode_ctrl #(.LOCK_CYCLES(LOCK)) dll_mode_ctrl_i (
        .clk_in(clk_in), .rst_in(rst_in), .ck_in(ck), .cke_in(pins.cke), .odt_in(pins.odt),
        .cs_n_in(pins.cs_n), .ras_n_in(pins.ras_n), .cas_n_in(pins.cas_n), .we_n_in(pins.we_n),
        .ba_in(pins.ba), .addr_in(pins.addr), .cas_latency_in(cl), .write_latency_in(cwl),
        .additive_latency_in(al), .dll_off_out(dll_off), .dll_locked_out(locked),
        .latency_ok_out(lat_ok), .read_strobe_delay_out(rsd), .self_refresh_out(sref),
        .power_down_out(pdown), .clock_ignored_out(ck_ign), .nop_out(nop));
    // ****
    // helpers
    // ****
    function automatic cmd_pins_s cmd(input logic [3:0] k, input logic e,
                                      input logic [1:0] b, input logic [12:0] a);
        return cmd_pins_s'({k, e, 1'b0, b, a});
    endfunction
    function automatic logic [4:0] exp_delay(input logic off);
        return 5'(al) + 5'(cl) - 5'(off);
    endfunction
    task automatic report_and_stop();
        if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial forever #2 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (nop === 1'b1) nops++;
        if (cycles == 10000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(32'h13677aae));
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        `CHECK(dll_off, 1'b0)
        `CHECK(lat_ok, 1'b1)
        for (int i = 0; i < 12; i++) begin
            c = (i == 0) ? 4'h6 : 4'($urandom_range(5, 11));
            r = $urandom_range(0, 2);
            cl <= c;
            al <= (r == 0) ? 4'h0 : c - 4'(r);
            cwl <= (i == 0) ? 4'h6 : 4'($urandom_range(5, 8));
            for (int k = 1; k >= 0; k--) begin
                ctrl_model_i.send(cmd(4'h0, 1'b1, 2'h1, {12'($urandom), k[0]}));
                `CHECK(dll_off, k[0])
                `CHECK(rsd, exp_delay(k[0]))
                `CHECK(lat_ok, !k[0] || (cl == 4'h6 && cwl == 4'h6))
                ctrl_model_i.send(cmd(4'h8, 1'b1, 2'h1, {12'h000, ~k[0]}));
                `CHECK(dll_off, k[0])
                base = nops;
                ctrl_model_i.send(cmd(4'h7, 1'b1, 2'h1, {12'h000, ~k[0]}));
                ctrl_model_i.send(cmd(4'h3, 1'b1, 2'h1, {12'h000, ~k[0]}));
                `CHECK(nops - base, 1)
                `CHECK(dll_off, k[0])
            end
        end
        // reset of the loop is refused while it is off
        ctrl_model_i.send(cmd(4'h0, 1'b1, 2'h1, 13'h0001));
        ctrl_model_i.send(cmd(4'h0, 1'b1, 2'h0, 13'h0100));
        repeat (LOCK + 2) @(posedge ck);
        `CHECK(locked, 1'b0)
        ctrl_model_i.send(cmd(4'h0, 1'b0, 2'h0, 13'h0000));
        `CHECK(sref, 1'b1)
        repeat (10) @(posedge ck);
        `CHECK(ck_ign, 1'b1)
        run <= 1'b0;
        repeat (60) @(posedge clk_in);
        run <= 1'b1;
        repeat (48) @(posedge clk_in);
        ctrl_model_i.send(cmd(4'h7, 1'b1, 2'h0, 13'h0000));
        `CHECK(sref, 1'b0)
        ctrl_model_i.send(cmd(4'h0, 1'b1, 2'h1, 13'h0000));
        `CHECK(dll_off, 1'b0)
        // a loop reset taken while off would show as locked here
        `CHECK(locked, 1'b0)
        // cke stays high from exit until lock; power-down only once locked
        for (int j = 0; j < 2; j++) begin
            ctrl_model_i.send(cmd(4'h0, 1'b1, 2'h0, 13'h0100));
            repeat (LOCK - 2) @(posedge ck);
            `CHECK(locked, 1'b0)
            repeat (4) @(posedge ck);
            repeat (8) @(posedge clk_in);
            `CHECK(locked, 1'b1)
            if (j == 0) begin
                ctrl_model_i.send(cmd(4'h7, 1'b0, 2'h0, 13'h0000));
                `CHECK(pdown, 1'b1)
                ctrl_model_i.send(cmd(4'h7, 1'b1, 2'h0, 13'h0000));
                `CHECK(pdown, 1'b0)
            end
        end
        report_and_stop();
    end
endmodule
